/* File: ebc_map.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH
`define EBC_OFF_WIDTH 12'h000
`define EBC_OFF_ASTATE 12'h004
`define EBC_OFF_WAIT 12'h008
`define EBC_OFF_IFTYPE 12'h00c
`define EBC_OFF_BUSCTL 12'h010
`define EBC_OFF_STATUS 12'h014
`define EBC_WIDTH_RST_HI 8'hff
`define EBC_WIDTH_RST_LO 8'h00
`define EBC_ASTATE_RST 8'hff
`define EBC_WAIT_RST 16'hffff
`define EBC_IFTYPE_RST 16'h0000
`define EBC_BUSCTL_RST 1'b0
`define EBC_BUSCTL_IDLE_BIT 0
`define EBC_WAIT_LO_BIT 0
`define EBC_WAIT_HI_BIT 1
`define EBC_MODE4 3'h4
`define EBC_IDLE_CYCLES 2'h1
`define EBC_STRAP_SETTLE 2'h3
`endif

/* File: ebc_pkg.sv */
// Types shared by the external area bus controller.
package ebc_pkg;
  typedef enum logic [1:0] {
    EBC_IF_BASIC,
    EBC_IF_DRAM,
    EBC_IF_BURST,
    EBC_IF_RSVD
  } ebc_iftype_t;
  typedef enum logic [2:0] {
    EBC_ST_IDLE,
    EBC_ST_GAP,
    EBC_ST_T1,
    EBC_ST_T2,
    EBC_ST_T3,
    EBC_ST_TW
  } ebc_state_t;
endpackage

/* File: ebc_area_decode.sv */
// Per-area setting lookup for the selected external area.
`timescale 1ns/100ps
module ebc_area_decode
  import ebc_pkg::*;
#(
  parameter int AREAS = 8
) (
  // Settings of all areas.
  input wire logic [AREAS-1:0] width_sel_in,
  input wire logic [AREAS-1:0] three_state_in,
  input wire logic [2*AREAS-1:0] wait_in,
  input wire logic [2*AREAS-1:0] iftype_in,
  // Selected area.
  input wire logic [2:0] area_in,
  // Settings for that area.
  output logic byte_wide_out,
  output logic three_state_out,
  output logic [1:0] waits_out,
  output ebc_iftype_t iftype_out
);
  logic [1:0] wait_pair [AREAS];
  logic [1:0] if_pair [AREAS];

  // One slice per area so the mux below can index plainly.
  for (genvar g = 0; g < AREAS; g++) begin : g_area
    assign wait_pair[g] = wait_in[2*g+1:2*g];
    assign if_pair[g] = iftype_in[2*g+1:2*g];
  end

  // Pick the settings; a set width bit means an 8-bit area.
  always_comb begin
    byte_wide_out = width_sel_in[area_in];
    three_state_out = three_state_in[area_in];
    waits_out = three_state_in[area_in] ? wait_pair[area_in] : 2'h0;
    iftype_out = ebc_iftype_t'(if_pair[area_in]);
  end
endmodule

/* File: ebc_top.sv */
// External area bus controller with APB configuration registers.
//
// Behaviour
// - Width bit per area: 0=16-bit, 1=8-bit.
// - Width applies only to external space.
// - Reset width: ones modes 5-7, zeros mode 4.
// - Software standby keeps the width register.
// - Two states, or three plus 0-3 waits.
// - Each area picks its interface type.
// - Interface type names the area's space kind.
// - Idle cycle when write follows read.
// - Reset aborts any bus cycle at once.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "ebc_map.svh"
module ebc_top
  import ebc_pkg::*;
#(
  parameter int AREAS = 8
) (
  // Clock, reset and enable.
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CLK_EN_IN,
  // Operating mode pins and standby.
  input wire logic [2:0] MODE_IN,
  input wire logic HW_STANDBY_IN,
  input wire logic SW_STANDBY_IN,
  // APB slave.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Access request from the core.
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic REQ_EXTERNAL_IN,
  input wire logic [2:0] REQ_AREA_IN,
  output logic REQ_READY_OUT,
  output logic DONE_OUT,
  // External bus strobes.
  output logic BUS_ACTIVE_OUT,
  output logic BUS_READ_OUT,
  output logic BUS_WRITE_OUT,
  output logic BUS_BYTE_WIDE_OUT,
  output logic [2:0] BUS_AREA_OUT,
  output logic [1:0] BUS_SPACE_OUT
);
  logic rst_s1_q;
  logic rst_n_q;
  logic [2:0] mode_s1_q, mode_q;
  logic hws_s1_q, hws_q;
  logic sws_s1_q, sws_q;
  logic [1:0] strap_cnt_q;
  logic [7:0] width_q;
  logic [AREAS-1:0] astate_q;
  logic [2*AREAS-1:0] wait_q;
  logic [2*AREAS-1:0] iftype_q;
  logic idle_en_q;
  ebc_state_t state_q, state_d;
  logic last_read_q;
  logic cur_write_q;
  logic cur_byte_q;
  logic [1:0] cur_waits_q;
  logic cur_three_q;
  logic [2:0] cur_area_q;
  logic [1:0] cur_space_q;
  logic [1:0] wait_cnt_q;
  logic dec_byte, dec_three;
  logic [1:0] dec_waits;
  ebc_iftype_t dec_if;
  logic apb_wr, apb_rd, addr_ok;
  logic start;
  logic [7:0] width_rst;

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Mode and standby pins come from outside, so two flops each.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_s1_q <= 3'h0;
      mode_q <= 3'h0;
      hws_s1_q <= 1'b0;
      hws_q <= 1'b0;
      sws_s1_q <= 1'b0;
      sws_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      mode_s1_q <= MODE_IN;
      mode_q <= mode_s1_q;
      hws_s1_q <= HW_STANDBY_IN;
      hws_q <= hws_s1_q;
      sws_s1_q <= SW_STANDBY_IN;
      sws_q <= sws_s1_q;
    end
  end

  assign width_rst = (mode_q == `EBC_MODE4) ? `EBC_WIDTH_RST_LO
                                            : `EBC_WIDTH_RST_HI;

  // APB decode; every access completes in its first access cycle.
  assign addr_ok = (PADDR_IN == `EBC_OFF_WIDTH) ||
                   (PADDR_IN == `EBC_OFF_ASTATE) ||
                   (PADDR_IN == `EBC_OFF_WAIT) ||
                   (PADDR_IN == `EBC_OFF_IFTYPE) ||
                   (PADDR_IN == `EBC_OFF_BUSCTL) ||
                   (PADDR_IN == `EBC_OFF_STATUS);
  assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && addr_ok;
  assign apb_rd = PSEL_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

  // Width register. The mode strap needs the synchroniser to settle
  // after release, so the strap value is reloaded until it has; a
  // single load at the first edge would still see the reset mode.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      width_q <= `EBC_WIDTH_RST_HI;
      strap_cnt_q <= `EBC_STRAP_SETTLE;
    end else if (CLK_EN_IN) begin
      if (strap_cnt_q != 2'h0 || hws_q) begin
        width_q <= width_rst;
        if (strap_cnt_q != 2'h0) begin
          strap_cnt_q <= strap_cnt_q - 2'h1;
        end
      end else if (apb_wr && PADDR_IN == `EBC_OFF_WIDTH) begin
        width_q <= PWDATA_IN[7:0];
      end
    end
  end

  // Other configuration; hardware standby resets, soft standby keeps.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      astate_q <= AREAS'(`EBC_ASTATE_RST);
      wait_q <= (2*AREAS)'(`EBC_WAIT_RST);
      iftype_q <= (2*AREAS)'(`EBC_IFTYPE_RST);
      idle_en_q <= `EBC_BUSCTL_RST;
    end else if (CLK_EN_IN) begin
      if (hws_q) begin
        astate_q <= AREAS'(`EBC_ASTATE_RST);
        wait_q <= (2*AREAS)'(`EBC_WAIT_RST);
        iftype_q <= (2*AREAS)'(`EBC_IFTYPE_RST);
        idle_en_q <= `EBC_BUSCTL_RST;
      end else if (apb_wr) begin
        case (PADDR_IN)
          `EBC_OFF_ASTATE: astate_q <= PWDATA_IN[AREAS-1:0];
          `EBC_OFF_WAIT: wait_q <= PWDATA_IN[2*AREAS-1:0];
          `EBC_OFF_IFTYPE: iftype_q <= PWDATA_IN[2*AREAS-1:0];
          `EBC_OFF_BUSCTL: idle_en_q <= PWDATA_IN[`EBC_BUSCTL_IDLE_BIT];
          default: ;
        endcase
      end
    end
  end

  // Read data from flops; status shows the engine's own state.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PRDATA_OUT <= 32'h0;
    end else if (CLK_EN_IN && apb_rd && !PENABLE_IN) begin
      case (PADDR_IN)
        `EBC_OFF_WIDTH: PRDATA_OUT <= {24'h0, width_q};
        `EBC_OFF_ASTATE: PRDATA_OUT <= 32'(astate_q);
        `EBC_OFF_WAIT: PRDATA_OUT <= 32'(wait_q);
        `EBC_OFF_IFTYPE: PRDATA_OUT <= 32'(iftype_q);
        `EBC_OFF_BUSCTL: PRDATA_OUT <= {31'h0, idle_en_q};
        `EBC_OFF_STATUS: PRDATA_OUT <= {24'h0, hws_q, sws_q,
                                       last_read_q, BUS_ACTIVE_OUT,
                                       1'b0, 3'(state_q)};
        default: PRDATA_OUT <= 32'h0;
      endcase
    end
  end

  ebc_area_decode #(
    .AREAS(AREAS)
  ) u_decode (
    .width_sel_in(width_q[AREAS-1:0]),
    .three_state_in(astate_q),
    .wait_in(wait_q),
    .iftype_in(iftype_q),
    .area_in(REQ_AREA_IN),
    .byte_wide_out(dec_byte),
    .three_state_out(dec_three),
    .waits_out(dec_waits),
    .iftype_out(dec_if)
  );

  // Only external requests reach the engine; internal ones never do.
  assign start = REQ_VALID_IN && REQ_EXTERNAL_IN &&
                 state_q == EBC_ST_IDLE;
  assign REQ_READY_OUT = (state_q == EBC_ST_IDLE) && !sws_q;

  // Access engine: T1, T2, optional T3 plus waits, idle on W-after-R.
  always_comb begin
    state_d = state_q;
    case (state_q)
      EBC_ST_IDLE: begin
        if (start && !sws_q) begin
          if (idle_en_q && REQ_WRITE_IN && last_read_q) begin
            state_d = EBC_ST_GAP;
          end else begin
            state_d = EBC_ST_T1;
          end
        end
      end
      EBC_ST_GAP: state_d = EBC_ST_T1;
      EBC_ST_T1: state_d = EBC_ST_T2;
      EBC_ST_T2: begin
        state_d = cur_three_q ? EBC_ST_T3 : EBC_ST_IDLE;
      end
      EBC_ST_T3: begin
        state_d = (wait_cnt_q == 2'h0) ? EBC_ST_IDLE : EBC_ST_TW;
      end
      EBC_ST_TW: begin
        state_d = (wait_cnt_q == 2'h1) ? EBC_ST_IDLE : EBC_ST_TW;
      end
      default: state_d = EBC_ST_IDLE;
    endcase
  end

  // Reset drops the state at once, aborting any cycle under way.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= EBC_ST_IDLE;
    end else if (CLK_EN_IN) begin
      state_q <= state_d;
    end
  end

  // Settings are latched at start so later writes cannot disturb it.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cur_write_q <= 1'b0;
      cur_byte_q <= 1'b0;
      cur_three_q <= 1'b0;
      cur_waits_q <= 2'h0;
      cur_area_q <= 3'h0;
      cur_space_q <= 2'h0;
    end else if (CLK_EN_IN && start && !sws_q) begin
      cur_write_q <= REQ_WRITE_IN;
      cur_byte_q <= dec_byte;
      cur_three_q <= dec_three;
      cur_waits_q <= dec_waits;
      cur_area_q <= REQ_AREA_IN;
      cur_space_q <= 2'(dec_if);
    end
  end

  // Wait counter loads at T2 and counts down through the waits.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_cnt_q <= 2'h0;
    end else if (CLK_EN_IN) begin
      if (state_q == EBC_ST_T2) begin
        wait_cnt_q <= cur_waits_q;
      end else if (state_q == EBC_ST_TW) begin
        wait_cnt_q <= wait_cnt_q - 2'h1;
      end
    end
  end

  // Remember whether the last finished external access was a read.
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      last_read_q <= 1'b0;
    end else if (CLK_EN_IN && DONE_OUT) begin
      last_read_q <= !cur_write_q;
    end
  end

  // Strobes follow the latched access; idle cycle drops active, read and write but still drives area, width and space.
  assign BUS_ACTIVE_OUT = state_q != EBC_ST_IDLE && state_q != EBC_ST_GAP;
  assign BUS_READ_OUT = BUS_ACTIVE_OUT && !cur_write_q;
  assign BUS_WRITE_OUT = BUS_ACTIVE_OUT && cur_write_q;
  assign BUS_BYTE_WIDE_OUT = cur_byte_q;
  assign BUS_AREA_OUT = cur_area_q;
  assign BUS_SPACE_OUT = cur_space_q;
  assign DONE_OUT = state_q != state_d && state_d == EBC_ST_IDLE;
endmodule

/* File: ebc_mem_model.sv */
// Far-side memory model that times each external access.
`timescale 1ns/100ps
module ebc_mem_model (
  // Clock, reset and bus strobe.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic active_in,
  // Bus states seen so far, this one included.
  output logic [2:0] len_out
);
  logic [2:0] cnt_q;
  // The memory sees one bus state per active clock.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= active_in ? cnt_q + 3'h1 : 3'h0;
    end
  end
  assign len_out = cnt_q + 3'h1;
endmodule

/* File: ebc_top_asserts.sv */
// Port assertions for the external area bus controller.
`timescale 1ns/100ps
module ebc_top_chk (
  // Clock and reset.
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  // Watched ports.
  input wire logic SW_STANDBY_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_EXTERNAL_IN,
  input wire logic REQ_READY_OUT,
  input wire logic DONE_OUT,
  input wire logic BUS_ACTIVE_OUT,
  input wire logic BUS_READ_OUT,
  input wire logic BUS_WRITE_OUT,
  input wire logic BUS_BYTE_WIDE_OUT,
  input wire logic [2:0] BUS_AREA_OUT,
  input wire logic [1:0] BUS_SPACE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic take;
  // An external request taken by an idle engine.
  assign take = REQ_VALID_IN && REQ_EXTERNAL_IN && REQ_READY_OUT;
  two_state_min_a:
    assert property ($rose(BUS_ACTIVE_OUT) |-> !DONE_OUT)
    else $error("access shorter than two states");
  wait_bound_a:
    assert property ($rose(BUS_ACTIVE_OUT) |-> ##[1:5] DONE_OUT)
    else $error("access longer than six states");
  strobe_qual_a:
    assert property (BUS_READ_OUT || BUS_WRITE_OUT |->
      BUS_ACTIVE_OUT && (BUS_READ_OUT != BUS_WRITE_OUT))
    else $error("strobe outside an access");
  internal_skip_a:
    assert property (REQ_VALID_IN && !REQ_EXTERNAL_IN && REQ_READY_OUT
      |=> !BUS_ACTIVE_OUT)
    else $error("internal access reached the bus");
  start_bound_a:
    assert property (take |-> ##[1:2] $rose(BUS_ACTIVE_OUT))
    else $error("access did not start in time");
  attr_hold_a:
    assert property (BUS_ACTIVE_OUT && !DONE_OUT |=>
      $stable(BUS_AREA_OUT) && $stable(BUS_BYTE_WIDE_OUT) &&
      $stable(BUS_SPACE_OUT))
    else $error("settings changed inside an access");
  // The standby pin passes two flops, so readiness lags it by two.
  ready_again_a:
    assert property (DONE_OUT && !$past(SW_STANDBY_IN) |=>
      REQ_READY_OUT)
    else $error("engine not ready after an access");
  standby_hold_a:
    assert property ($past(SW_STANDBY_IN, 2) |-> !REQ_READY_OUT)
    else $error("request accepted in software standby");
  reset_abort_a:
    assert property ($rose(ARST_N_IN) |-> !BUS_ACTIVE_OUT && !DONE_OUT)
    else $error("bus cycle survived reset");
endmodule
bind ebc_top ebc_top_chk u_chk (.REF_CLK_IN, .ARST_N_IN, .SW_STANDBY_IN,
  .REQ_VALID_IN, .REQ_EXTERNAL_IN, .REQ_READY_OUT, .DONE_OUT,
  .BUS_ACTIVE_OUT, .BUS_READ_OUT, .BUS_WRITE_OUT, .BUS_BYTE_WIDE_OUT,
  .BUS_AREA_OUT, .BUS_SPACE_OUT);

/* File: tb_ebc_top.sv */
// Self-checking testbench for the external area bus controller.
`timescale 1ns/100ps
`include "ebc_map.svh"
module tb_ebc_top;
  logic clk = 0, rst_n = 0, sw_sb = 0, psel = 0, pen = 0, pw = 0;
  logic valid = 0, wr = 0, ext = 0, prdy, perr, err, rdy, done, act, bw;
  logic hw_sb = 0, brd, bwr;
  logic [2:0] mode = 3'h5, area = 0, len, ba;
  logic [1:0] sp;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd, seed = 32'h7ee4ea78;
  logic [7:0] wd = 8'hff, as = 8'hff;
  logic [15:0] wt = 16'hffff, it = 16'h0;
  logic idle_en = 0, last_rd = 0;
  logic [12:0] q[$], e;
  int n_errors = 0, tests_run = 0, t = 0;
  logic [11:0] ofs[5] = '{`EBC_OFF_WIDTH, `EBC_OFF_ASTATE, `EBC_OFF_WAIT,
    `EBC_OFF_IFTYPE, `EBC_OFF_BUSCTL};
  logic [31:0] rv[5] = '{32'hff, 32'hff, 32'hffff, 32'h0, 32'h0};
  always #20 clk = ~clk;
  ebc_top u_ebc_top (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .CLK_EN_IN(1'h1),
    .MODE_IN(mode), .HW_STANDBY_IN(hw_sb), .SW_STANDBY_IN(sw_sb),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pw), .PADDR_IN(pa),
    .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .REQ_VALID_IN(valid), .REQ_WRITE_IN(wr),
    .REQ_EXTERNAL_IN(ext), .REQ_AREA_IN(area), .REQ_READY_OUT(rdy),
    .DONE_OUT(done), .BUS_ACTIVE_OUT(act), .BUS_READ_OUT(brd),
    .BUS_WRITE_OUT(bwr), .BUS_BYTE_WIDE_OUT(bw), .BUS_AREA_OUT(ba),
    .BUS_SPACE_OUT(sp));
  ebc_mem_model u_ebc_mem_model (.clk_in(clk), .rst_n_in(rst_n),
    .active_in(act), .len_out(len));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer; waits for pready however long it takes.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (prdy !== 1'h1);
    rd = prd;
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Issues a request and notes the expected access once it is taken.
  task acc(input logic [2:0] a, input logic w, input logic x);
    logic [2:0] n;
    @(posedge clk);
    valid <= 1'h1;
    area <= a;
    wr <= w;
    ext <= x;
    do @(posedge clk); while (rdy !== 1'h1);
    valid <= 1'h0;
    n = as[a] ? 3'h3 + wt[2*a+:2] : 3'h2;
    if (x) q.push_back({a, w, wd[a], it[2*a+:2], n,
      n + 3'(w & last_rd & idle_en)});
    if (x) last_rd = !w;
  endtask
  // Counts clocks from the taken request and checks each finished access.
  always @(posedge clk) begin
    t = (valid && ext && rdy) ? 0 : t + 1;
    if (done === 1'h1) begin
      e = q.size() > 0 ? q.pop_front() : 13'h1fff;
      chk("area", ba, e[12:10]);
      chk("write", bwr, e[9]);
      chk("read", brd, !e[9]);
      chk("width", bw, e[8]);
      chk("space", sp, e[7:6]);
      chk("states", len, e[5:3]);
      chk("latency", t, e[2:0]);
    end
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      apb(1'h0, ofs[k], 32'h0);
      chk("reset value", rd, rv[k]);
    end
    apb(1'h0, 12'h018, 32'h0);
    chk("unmapped error", err, 1'h1);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      wd = seed[7:0];
      as = seed[15:8];
      as[i%8] = i[2];
      wt = seed[31:16];
      wt[2*(i%8)+:2] = i[1:0];
      it = seed[23:8];
      it[2*(i%8)+:2] = i[3:2];
      idle_en = i[3];
      for (int k = 0; k < 5; k++) begin
        apb(1'h1, ofs[k], k == 0 ? wd : k == 1 ? as : k == 2 ? wt :
          k == 3 ? it : 32'(idle_en));
      end
      apb(1'h0, `EBC_OFF_WIDTH, 32'h0);
      chk("width readback", rd, wd);
      acc(i[2:0], i[0], 1'h1);
    end
    acc(3'h2, 1'h0, 1'h0);
    // One edge after the take is when a wrongly started access shows.
    repeat (1) @(posedge clk);
    chk("internal access", act, 1'h0);
    $display("test area accesses done");
    wd = 8'h5a;
    apb(1'h1, `EBC_OFF_WIDTH, 32'h5a);
    sw_sb <= 1'h1;
    repeat (4) @(posedge clk);
    chk("standby ready", rdy, 1'h0);
    sw_sb <= 1'h0;
    apb(1'h0, `EBC_OFF_WIDTH, 32'h0);
    chk("width kept", rd, 32'h5a);
    $display("test standby done");
    hw_sb <= 1'h1;
    repeat (4) @(posedge clk);
    hw_sb <= 1'h0;
    apb(1'h0, `EBC_OFF_WIDTH, 32'h0);
    chk("hw standby width", rd, 32'hff);
    $display("test hardware standby done");
    apb(1'h1, `EBC_OFF_ASTATE, 32'hff);
    apb(1'h1, `EBC_OFF_WAIT, 32'hffff);
    acc(3'h1, 1'h0, 1'h1);
    repeat (2) @(posedge clk);
    rst_n <= 1'h0;
    mode <= 3'h4;
    #1;
    chk("aborted cycle", act, 1'h0);
    q.delete();
    {wd, as, wt, it, idle_en, last_rd} = {8'h0, 8'hff, 16'hffff, 16'h0, 2'h0};
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    apb(1'h0, `EBC_OFF_WIDTH, 32'h0);
    chk("mode 4 width", rd, 32'h0);
    acc(3'h0, 1'h1, 1'h1);
    repeat (10) @(posedge clk);
    $display("test reset abort done");
    tally_and_finish;
  end
endmodule
